// [aux_digital_io_port.sv]
// Auxiliary digital I/O port: register access, groups and special inputs
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps

module aux_digital_io_port (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  // Register port
  input wire logic [15:0] I_ADDR,
  input wire logic [31:0] I_WR_DATA,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  output logic [31:0] O_RD_DATA,
  // Auxiliary lines, split into input, output and enable
  input wire logic [7:0] I_AUX_LINE,
  output logic [7:0] O_AUX_LINE,
  output logic [7:0] O_AUX_LINE_OE,
  // Special input feeds to trigger and timestamp logic
  output logic O_EXTRA_TRIGGER_A,
  output logic O_EXTRA_TRIGGER_B,
  output logic O_TIMESTAMP_REF_CLOCK
);

  localparam int LW = aux_io_pkg::LINE_COUNT;
  localparam int GW = aux_io_pkg::GROUP_W;
  localparam int GN = aux_io_pkg::GROUP_COUNT;
  localparam int DFW = aux_io_pkg::DIR_FIELD_W;
  localparam int BW = aux_io_pkg::DATA_FIELD_W;

  typedef struct packed {
    logic [31:0] rd_data;
    logic trig_a;
    logic trig_b;
    logic ref_clk;
  } port_state_t;

  port_state_t state_reg;
  port_state_t state_next;

  // Address decode
  logic hit_dir;
  logic hit_data;
  logic dir_we;
  logic data_we;

  // Group outputs, each straight from a group flop
  logic [LW-1:0] line_out;
  logic [LW-1:0] line_oe;

  // Current group directions, one enable flop per group stands for it
  logic dir_lower;
  logic dir_upper;

  // Decode of the two mapped offsets
  assign hit_dir = (I_ADDR == aux_io_pkg::DIR_OFFSET);
  assign hit_data = (I_ADDR == aux_io_pkg::DATA_OFFSET);
  assign dir_we = I_WR_EN && hit_dir;
  assign data_we = I_WR_EN && hit_data;

  // Direction bit of each group taken from one enable flop of that group
  assign dir_lower = line_oe[0];
  assign dir_upper = line_oe[GW];

  // Two identical groups; each picks its own direction bit and data nibble.
  // Keeping both groups in one module type means they cannot drift apart.
  for (genvar g = 0; g < GN; g++) begin : g_group
    aux_line_group #(
      .GROUP_W(GW)
    ) u_group (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_dir_we(dir_we),
      .i_dir_val(I_WR_DATA[g]),
      .i_data_we(data_we),
      .i_data_val(I_WR_DATA[g*GW +: GW]),
      .o_line(line_out[g*GW +: GW]),
      .o_oe(line_oe[g*GW +: GW])
    );
  end

  // Next state: read answer and the gated special feeds.
  // Line 3 is deliberately not routed anywhere but the read path.
  always_comb begin
    state_next = state_reg;
    // Read data stand for one cycle only, then fall back to idle
    state_next.rd_data = aux_io_pkg::RD_IDLE;
    if (I_RD_EN) begin
      if (hit_dir) begin
        state_next.rd_data[DFW-1:0] = {dir_upper, dir_lower};
      end else if (hit_data) begin
        // Pins read live whatever their direction; no masking here
        state_next.rd_data[BW-1:0] = I_AUX_LINE;
      end
    end
    // Special feeds only while the lower group is receiving; an output
    // group would otherwise loop its own pattern into the trigger logic
    state_next.trig_a = !dir_lower &&
                        I_AUX_LINE[aux_io_pkg::LINE_TRIG_A];
    state_next.trig_b = !dir_lower &&
                        I_AUX_LINE[aux_io_pkg::LINE_TRIG_B];
    state_next.ref_clk = !dir_lower &&
                         I_AUX_LINE[aux_io_pkg::LINE_REF_CLK];
  end

  // State register with synchronous reset
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      state_reg.rd_data <= aux_io_pkg::RD_IDLE;
      state_reg.trig_a <= 1'h0;
      state_reg.trig_b <= 1'h0;
      state_reg.ref_clk <= 1'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs, all from flops here or inside the groups
  assign O_RD_DATA = state_reg.rd_data;
  assign O_AUX_LINE = line_out;
  assign O_AUX_LINE_OE = line_oe;
  assign O_EXTRA_TRIGGER_A = state_reg.trig_a;
  assign O_EXTRA_TRIGGER_B = state_reg.trig_b;
  assign O_TIMESTAMP_REF_CLOCK = state_reg.ref_clk;

  // Checks on the behaviour above, all in the single clock domain
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  // Both groups follow one direction write together
  dir_write_both_a: assert property (
    dir_we |=> (dir_lower == $past(I_WR_DATA[0])) &&
               (dir_upper == $past(I_WR_DATA[1]))
  ) else $error("direction write did not set both groups");

  // Value 1 drives the lower four lines, all four together
  lower_group_oe_a: assert property (
    (dir_we && I_WR_DATA[0]) |=> (O_AUX_LINE_OE[3:0] == 4'hF)
  ) else $error("lower group not driving after value 1");

  // Value 2 drives the upper four lines, all four together
  upper_group_oe_a: assert property (
    (dir_we && I_WR_DATA[1]) |=> (O_AUX_LINE_OE[7:4] == 4'hF)
  ) else $error("upper group not driving after value 2");

  // Zero releases both groups
  dir_zero_input_a: assert property (
    (dir_we && (I_WR_DATA[1:0] == 2'h0)) |=> (O_AUX_LINE_OE == 8'h00)
  ) else $error("direction zero left a line driven");

  // Direction holds while no direction write comes
  dir_hold_a: assert property (
    !dir_we |=> $stable(O_AUX_LINE_OE)
  ) else $error("direction changed without a write");

  // Data write to an output group drives the low byte bits of that group
  lower_drive_a: assert property (
    (data_we && dir_lower) |=> (O_AUX_LINE[3:0] == $past(I_WR_DATA[3:0]))
  ) else $error("lower output pattern not taken from write");

  // Data write to an input group is dropped
  lower_discard_a: assert property (
    (data_we && !dir_lower) |=> $stable(O_AUX_LINE[3:0])
  ) else $error("input group took written data");

  // Upper group stays writable while the lower group receives
  upper_free_a: assert property (
    (data_we && dir_upper && !dir_lower) |=>
      (O_AUX_LINE[7:4] == $past(I_WR_DATA[7:4]))
  ) else $error("upper group blocked while lower receives");

  // Read of data gives the pins of the request cycle, upper bytes zero
  data_read_live_a: assert property (
    (I_RD_EN && hit_data) |=>
      (O_RD_DATA == {24'h00_0000, $past(I_AUX_LINE)})
  ) else $error("data read not equal to sampled pins");

  // Read of direction gives the two group bits
  dir_read_a: assert property (
    (I_RD_EN && hit_dir) |=>
      (O_RD_DATA == {30'h0000_0000, $past(dir_upper), $past(dir_lower)})
  ) else $error("direction read wrong");

  // Read data fall back to idle one cycle after an idle cycle
  rd_idle_a: assert property (
    !I_RD_EN |=> (O_RD_DATA == 32'h0000_0000)
  ) else $error("read data stood beyond one cycle");

  // First trigger feed follows line 0 only while lower group receives
  trig_a_gate_a: assert property (
    1'b1 |=> (O_EXTRA_TRIGGER_A ==
              ($past(I_AUX_LINE[0]) && !$past(dir_lower)))
  ) else $error("extra trigger a not gated by direction");

  // Second trigger feed follows line 1 the same way
  trig_b_gate_a: assert property (
    1'b1 |=> (O_EXTRA_TRIGGER_B ==
              ($past(I_AUX_LINE[1]) && !$past(dir_lower)))
  ) else $error("extra trigger b not gated by direction");

  // Reference clock feed follows line 2
  ref_clk_gate_a: assert property (
    1'b1 |=> (O_TIMESTAMP_REF_CLOCK ==
              ($past(I_AUX_LINE[2]) && !$past(dir_lower)))
  ) else $error("reference clock not gated by direction");

  // Line 3 reaches no special feed: toggling it alone moves none of them
  line3_plain_a: assert property (
    ($changed(I_AUX_LINE[3]) && $stable(I_AUX_LINE[2:0]) &&
     $stable(dir_lower)) |=>
      $stable({O_EXTRA_TRIGGER_A, O_EXTRA_TRIGGER_B, O_TIMESTAMP_REF_CLOCK})
  ) else $error("line 3 disturbed a special feed");

  // Coming out of reset nothing drives
  reset_release_a: assert property (
    $rose(I_RST_B) |-> (O_AUX_LINE_OE == 8'h00)
  ) else $error("line driven right after reset");

  // Clearing bit 0 in a direction write releases the lower four lines
  lower_group_off_a: assert property (
    (dir_we && !I_WR_DATA[0]) |=> (O_AUX_LINE_OE[3:0] == 4'h0)
  ) else $error("lower group still driving after clear");

  // Clearing bit 1 releases the upper four lines
  upper_group_off_a: assert property (
    (dir_we && !I_WR_DATA[1]) |=> (O_AUX_LINE_OE[7:4] == 4'h0)
  ) else $error("upper group still driving after clear");

  // Bits above the two group bits of a direction write change nothing
  dir_field_only_a: assert property (
    dir_we |=> (O_AUX_LINE_OE ==
      {{4{$past(I_WR_DATA[1])}}, {4{$past(I_WR_DATA[0])}}})
  ) else $error("direction write took bits beyond the two groups");

  // Lower buffer turns as one: all four lines driven or none
  lower_oe_whole_a: assert property (
    (O_AUX_LINE_OE[3:0] == 4'h0) ||
    (O_AUX_LINE_OE[3:0] == 4'hF)
  ) else $error("lower group enables split");

  // Upper buffer turns as one as well
  upper_oe_whole_a: assert property (
    (O_AUX_LINE_OE[7:4] == 4'h0) ||
    (O_AUX_LINE_OE[7:4] == 4'hF)
  ) else $error("upper group enables split");

  // Value 1 alone gives four outputs below, four inputs above
  mixed_lower_out_a: assert property (
    (dir_we && (I_WR_DATA[1:0] == 2'h1)) |=> (O_AUX_LINE_OE == 8'h0F)
  ) else $error("mixed mode with lower outputs wrong");

  // Value 2 alone gives four inputs below, four outputs above
  mixed_upper_out_a: assert property (
    (dir_we && (I_WR_DATA[1:0] == 2'h2)) |=> (O_AUX_LINE_OE == 8'hF0)
  ) else $error("mixed mode with upper outputs wrong");

  // Both values together drive all eight lines
  all_out_a: assert property (
    (dir_we && (I_WR_DATA[1:0] == 2'h3)) |=> (O_AUX_LINE_OE == 8'hFF)
  ) else $error("all-output mode wrong");

  // Data write to an upper output group drives bits 7..4
  upper_drive_a: assert property (
    (data_we && dir_upper) |=>
      (O_AUX_LINE[7:4] == $past(I_WR_DATA[7:4]))
  ) else $error("upper output pattern not taken from write");

  // Data write to an upper input group is dropped
  upper_discard_a: assert property (
    (data_we && !dir_upper) |=> $stable(O_AUX_LINE[7:4])
  ) else $error("upper input group took written data");

  // Driven pattern only moves on a data write
  line_hold_a: assert property (
    !data_we |=> $stable(O_AUX_LINE)
  ) else $error("driven pattern changed without a data write");

  // With both groups out the whole low byte reaches the lines
  byte_write_a: assert property (
    (data_we && dir_lower && dir_upper) |=>
      (O_AUX_LINE == $past(I_WR_DATA[7:0]))
  ) else $error("low byte of data write not driven");

  // Lines and enables move only when software writes
  sw_control_a: assert property (
    !I_WR_EN |=> $stable({O_AUX_LINE, O_AUX_LINE_OE})
  ) else $error("lines moved without a register write");

  // Unmapped reads answer zero
  unmapped_read_a: assert property (
    (I_RD_EN && !hit_dir && !hit_data) |=>
      (O_RD_DATA == 32'h0000_0000)
  ) else $error("unmapped read gave nonzero data");

  // Data read carries nothing above the low byte
  data_read_high_a: assert property (
    (I_RD_EN && hit_data) |=> (O_RD_DATA[31:8] == 24'h00_0000)
  ) else $error("data read upper bytes not zero");

  // Direction read carries nothing above the two group bits
  dir_read_high_a: assert property (
    (I_RD_EN && hit_dir) |=> (O_RD_DATA[31:2] == 30'h0000_0000)
  ) else $error("direction read upper bits not zero");

  // Lower group driving keeps every special feed low
  feeds_silent_a: assert property (
    dir_lower |=>
      ({O_EXTRA_TRIGGER_A, O_EXTRA_TRIGGER_B, O_TIMESTAMP_REF_CLOCK} == 3'h0)
  ) else $error("special feed active while lower group drives");

  // Lower lines stay plain readable inputs while feeding specials
  plain_inputs_a: assert property (
    (I_RD_EN && hit_data && !dir_lower) |=>
      (O_RD_DATA[3:0] == $past(I_AUX_LINE[3:0]))
  ) else $error("lower inputs not readable during special use");

  // Line 3 is read like any other input
  line3_read_a: assert property (
    (I_RD_EN && hit_data) |=> (O_RD_DATA[3] == $past(I_AUX_LINE[3]))
  ) else $error("line 3 not seen on data read");

  // Lines in special use are still sampled by a data read
  special_sampled_a: assert property (
    (I_RD_EN && hit_data) |=>
      (O_RD_DATA[2:0] == $past(I_AUX_LINE[2:0]))
  ) else $error("special lines missing from data read");

  // Out of reset the pattern and the read port are quiet too
  reset_quiet_a: assert property (
    $rose(I_RST_B) |-> (O_AUX_LINE == 8'h00) &&
      (O_RD_DATA == 32'h0000_0000)
  ) else $error("pattern or read data set right after reset");

  // A write never puts anything on the read data
  write_quiet_read_a: assert property (
    I_WR_EN |=> (O_RD_DATA == 32'h0000_0000)
  ) else $error("read data appeared after a write");

  // Reading the direction leaves it as it was
  dir_read_keep_a: assert property (
    (I_RD_EN && hit_dir) |=> $stable(O_AUX_LINE_OE)
  ) else $error("direction read changed the direction");

  // Reading the data leaves the driven pattern alone
  data_read_keep_a: assert property (
    I_RD_EN |=> $stable(O_AUX_LINE)
  ) else $error("data read changed the driven pattern");

endmodule

// [aux_digital_io_port_tb_top.sv]
// Self-checking testbench of the auxiliary digital I/O port
`timescale 1ns/100ps

module aux_digital_io_port_tb_top;
  logic clk;
  logic rst_b;
  logic [15:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic [7:0] pin;
  logic [7:0] line_out;
  logic [7:0] line_oe;
  logic trig_a;
  logic trig_b;
  logic ref_clk;
  logic [7:0] eq_en;
  logic [7:0] eq_val;
  logic [31:0] got;
  logic [7:0] held;
  logic [7:0] mask;
  logic [7:0] b;
  logic [7:0] exp_pin;
  int fail_count;
  int check_count;

  aux_digital_io_port aux_digital_io_port_inst (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WR_DATA(wr_data),
    .I_WR_EN(wr_en), .I_RD_EN(rd_en), .O_RD_DATA(rd_data),
    .I_AUX_LINE(pin), .O_AUX_LINE(line_out), .O_AUX_LINE_OE(line_oe),
    .O_EXTRA_TRIGGER_A(trig_a), .O_EXTRA_TRIGGER_B(trig_b),
    .O_TIMESTAMP_REF_CLOCK(ref_clk)
  );

  aux_line_equipment aux_line_equipment_inst (
    .i_clk(clk), .i_line(line_out), .i_line_oe(line_oe),
    .i_drive_en(eq_en), .i_drive_val(eq_val), .o_pin(pin)
  );

  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // Each access holds its strobe for exactly one cycle, then drops it
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 got = rd_data;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
  endtask

  // Equipment drives only the lines the port receives
  task automatic set_dir(input logic [1:0] d);
    wr(aux_io_pkg::DIR_OFFSET, 32'hFFFF_FFF0 | {30'h0000_0000, d});
    mask = {{4{d[1]}}, {4{d[0]}}};
    eq_en <= ~mask;
  endtask

  task automatic close_out();
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 140 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    addr = 16'h0000;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    eq_en = 8'hFF;
    eq_val = 8'h3C;
    held = 8'h00;
    mask = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    idle(1);
    chk({24'h00_0000, line_oe}, 32'h0000_0000);
    rd(aux_io_pkg::DIR_OFFSET);
    chk(got, 32'h0000_0000);
    rd(aux_io_pkg::DATA_OFFSET);
    chk(got, 32'h0000_003C);
    // Every direction code, each followed at once by data write and read
    for (int d = 0; d < 4; d++) begin
      set_dir(d[1:0]);
      b = 8'h5A ^ 8'(d * 51);
      wr(aux_io_pkg::DATA_OFFSET, 32'hDEAD_BE00 | {24'h0000_00, b});
      held = (held & ~mask) | (b & mask);
      rd(aux_io_pkg::DATA_OFFSET);
      exp_pin = (held & mask) | (eq_val & ~mask);
      chk(got, {24'h00_0000, exp_pin});
      chk({24'h0000_00, line_oe}, {24'h0000_00, mask});
      chk({24'h0000_00, line_out & mask}, {24'h0000_00, held & mask});
      rd(aux_io_pkg::DIR_OFFSET);
      chk(got, 32'(d));
    end
    // Special inputs: lower group kept input, upper group output
    set_dir(2'h2);
    idle(2);
    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      eq_val <= 8'(v);
      idle(1);
      chk({29'h0000_0000, ref_clk, trig_b, trig_a},
          32'(v & 7));
      rd(aux_io_pkg::DATA_OFFSET);
      chk(got, {24'h0000_00, held[7:4], 4'(v)});
    end
    // Line 3 alone moves: no feed follows it, the read path does
    @(posedge clk);
    eq_val <= 8'h07;
    idle(1);
    chk({29'h0000_0000, ref_clk, trig_b, trig_a}, 32'h0000_0007);
    rd(aux_io_pkg::DATA_OFFSET);
    chk(got, {24'h00_0000, held[7:4], 4'h7});
    // Lower group as output silences the special feeds
    set_dir(2'h3);
    idle(2);
    chk({29'h0000_0000, ref_clk, trig_b, trig_a}, 32'h0000_0000);
    // Unmapped place: write ignored, read gives zero; a data read then stands one cycle only
    wr(16'hB800, 32'h0000_0000);
    rd(16'hB800);
    chk(got, 32'h0000_0000);
    chk({24'h0000_00, line_oe}, 32'h0000_00FF);
    rd(aux_io_pkg::DATA_OFFSET);
    chk(got, {24'h0000_00, held});
    idle(1);
    chk(rd_data, 32'h0000_0000);
    close_out();
  end
endmodule

// [aux_io_pkg.sv]
// Constants, field positions and reset values of the auxiliary I/O port
//
// Behaviour
// - Eight auxiliary lines in two four-line groups, each with its own buffer.
// - Lines run apart from the main data path, under direct software control.
// - Each group's direction is set apart: all in, all out, or mixed.
// - Direction value 1 makes lines 3..0 outputs; clear leaves them inputs.
// - Direction value 2 makes lines 7..4 outputs.
// - A group contributing value 0 is inputs; direction zero means all inputs.
// - One direction write sets both groups from the OR of their values.
// - With special inputs in use, the upper group stays freely programmable.
// - Input lines 0 and 1 also feed two extra trigger inputs.
// - Input line 2 also serves as the timestamp reference clock.
// - Line 3 has no special use; it is a plain input only.
// - Lower lines not in special use still work as plain inputs.
// - A data read samples every line, special ones too; software masks.
// - Data read returns live pin levels, so outputs read back their pattern.
// - Data write drives only output groups; line n maps to bit n.
// - Data write ignores all bits above the lowest byte.

package aux_io_pkg;

  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Line geometry
  localparam int LINE_COUNT = 8;
  localparam int GROUP_W = 4;
  localparam int GROUP_COUNT = 2;

  // Register offsets as printed
  localparam logic [15:0] DIR_OFFSET = 16'hB7FC;
  localparam logic [15:0] DATA_OFFSET = 16'hB806;

  // Direction register fields: value 1 lower out, value 2 upper out
  localparam int DIR_LOWER_BIT = 0;
  localparam int DIR_UPPER_BIT = 1;
  localparam int DIR_FIELD_W = 2;
  localparam logic [1:0] DIR_RESET = 2'h0;

  // Data register field: only the lowest byte reaches the lines
  localparam int DATA_FIELD_W = 8;
  localparam logic [3:0] GROUP_DATA_RESET = 4'h0;

  // Answer on an unmapped address or an idle cycle
  localparam logic [31:0] RD_IDLE = 32'h0000_0000;

  // Lower group line positions: three with extra uses, then the plain line
  localparam int LINE_TRIG_A = 0;
  localparam int LINE_TRIG_B = 1;
  localparam int LINE_REF_CLK = 2;
  localparam int LINE_PLAIN = 3;

endpackage

// [aux_line_equipment.sv]
// Model of the external equipment wired to the eight auxiliary lines
`timescale 1ns/100ps

module aux_line_equipment (
  // Clock
  input wire logic i_clk,
  // Port side of each line
  input wire logic [7:0] i_line,
  input wire logic [7:0] i_line_oe,
  // Equipment drive per line
  input wire logic [7:0] i_drive_en,
  input wire logic [7:0] i_drive_val,
  // Resolved line level
  output logic [7:0] o_pin
);
  logic [7:0] last_reg = 8'h00;

  // Port drive wins over the equipment.
  // An undriven line has no pull, so it toggles rather than holding a level.
  assign o_pin = (i_line_oe & i_line) |
                 (~i_line_oe & i_drive_en & i_drive_val) |
                 (~i_line_oe & ~i_drive_en & ~last_reg);

  // Remember the level so a floating line never repeats it
  always_ff @(posedge i_clk) begin
    last_reg <= o_pin;
  end
endmodule

// [aux_line_group.sv]
// One four-line buffer group: direction bit and held output pattern
`timescale 1ns/100ps

module aux_line_group #(
  parameter int GROUP_W = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Direction write
  input wire logic i_dir_we,
  input wire logic i_dir_val,
  // Data write
  input wire logic i_data_we,
  input wire logic [GROUP_W-1:0] i_data_val,
  // Pin drive
  output logic [GROUP_W-1:0] o_line,
  output logic [GROUP_W-1:0] o_oe
);

  typedef struct packed {
    logic [GROUP_W-1:0] oe;
    logic [GROUP_W-1:0] data;
  } group_state_t;

  group_state_t state_reg;
  group_state_t state_next;

  // Next state; the enable is one flop per line so every pin sees a flop
  always_comb begin
    state_next = state_reg;
    if (i_dir_we) begin
      state_next.oe = {GROUP_W{i_dir_val}};
    end
    // Writes to an input group are dropped, not held for later
    if (i_data_we && state_reg.oe[0]) begin
      state_next.data = i_data_val;
    end
  end

  // Synchronous reset leaves the group receiving
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg.oe <= '0;
      state_reg.data <= aux_io_pkg::GROUP_DATA_RESET[GROUP_W-1:0];
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_line = state_reg.data;
  assign o_oe = state_reg.oe;

endmodule
